// File: logic/two_wire_bitbang_top.v
/*
 * Two software-driven two-wire ports behind a static memory bus slave.
 * Assumes the static memory strobes, address and data come from another
 * clock domain and stay stable while the strobes are active; the two
 * serial lines of each link are pulled up on the board.
 */
`include "two_wire_bitbang_map.vh"

module two_wire_bitbang_top #(
  parameter ADDR_WIDTH = 20,
  parameter DATA_WIDTH = 32
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_reset,
  // Static memory bus, strobes active low
  input wire i_cs_n,
  input wire i_we_n,
  input wire i_oe_n,
  input wire [ADDR_WIDTH-1:0] i_addr,
  input wire [DATA_WIDTH-1:0] i_wdata,
  output reg [DATA_WIDTH-1:0] o_rdata,
  output reg o_data_oe,
  // Link 0: switch configuration slave
  input wire i_link0_scl_in,
  output reg o_link0_scl_out,
  output wire o_link0_scl_oe,
  input wire i_link0_sda_in,
  output reg o_link0_sda_out,
  output wire o_link0_sda_oe,
  // Link 1: display data channel
  input wire i_link1_scl_in,
  output reg o_link1_scl_out,
  output wire o_link1_scl_oe,
  input wire i_link1_sda_in,
  output reg o_link1_sda_out,
  output wire o_link1_sda_oe
);

  // Bus synchronisers: first stage feeds only the second
  reg [2:0] strobe_meta;
  reg [2:0] strobe_sync;
  reg [ADDR_WIDTH-1:0] addr_meta;
  reg [ADDR_WIDTH-1:0] addr_sync;
  reg [DATA_WIDTH-1:0] wdata_meta;
  reg [DATA_WIDTH-1:0] wdata_sync;
  reg [1:0] write_seen;

  wire cs_active;
  wire we_active;
  wire oe_active;
  wire write_start;

  // Per-link strobes and state
  reg [1:0] link0_set;
  reg [1:0] link0_clear;
  reg [1:0] link1_set;
  reg [1:0] link1_clear;
  wire [1:0] link0_state;
  wire [1:0] link1_state;
  reg [DATA_WIDTH-1:0] next_rdata;

  function addr_hit;
    input [ADDR_WIDTH-1:0] addr;
    input [ADDR_WIDTH-1:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  function [1:0] write_mask;
    input [DATA_WIDTH-1:0] data;
    begin
      write_mask = {data[`DATA_BIT], data[`CLOCK_BIT]};
    end
  endfunction

  function [DATA_WIDTH-1:0] state_word;
    input [1:0] state;
    begin
      state_word = `READ_ZERO;
      state_word[`CLOCK_BIT] = state[0];
      state_word[`DATA_BIT] = state[1];
    end
  endfunction

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      strobe_meta <= `STROBES_IDLE;
      strobe_sync <= `STROBES_IDLE;
      addr_meta <= {ADDR_WIDTH{1'b0}};
      addr_sync <= {ADDR_WIDTH{1'b0}};
      wdata_meta <= {DATA_WIDTH{1'b0}};
      wdata_sync <= {DATA_WIDTH{1'b0}};
    end else begin
      strobe_meta <= {i_oe_n, i_we_n, i_cs_n};
      strobe_sync <= strobe_meta;
      addr_meta <= i_addr;
      addr_sync <= addr_meta;
      wdata_meta <= i_wdata;
      wdata_sync <= wdata_meta;
    end
  end

  assign cs_active = ~strobe_sync[0];
  assign we_active = cs_active & ~strobe_sync[1];
  assign oe_active = cs_active & ~strobe_sync[2] & ~we_active;
  // One register action per write strobe, however long it is held.
  // Acting a cycle after the synced strobe lets skewed address and
  // data bits settle through both flops first.
  assign write_start = we_active & write_seen[0] & ~write_seen[1];

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      write_seen <= 2'h0;
    end else begin
      write_seen <= {write_seen[0], we_active};
    end
  end

  // Write decode into one-cycle set and clear strobes
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      link0_set <= 2'h0;
      link0_clear <= 2'h0;
      link1_set <= 2'h0;
      link1_clear <= 2'h0;
    end else begin
      link0_set <= 2'h0;
      link0_clear <= 2'h0;
      link1_set <= 2'h0;
      link1_clear <= 2'h0;
      if (write_start) begin
        if (addr_hit(addr_sync, `LINK0_OUTPUT_SET_ADDR)) begin
          link0_set <= write_mask(wdata_sync);
        end
        if (addr_hit(addr_sync, `LINK1_OUTPUT_SET_ADDR)) begin
          link1_set <= write_mask(wdata_sync);
        end
        if (addr_hit(addr_sync, `LINK0_OUTPUT_CLEAR_ADDR)) begin
          link0_clear <= write_mask(wdata_sync);
        end
        if (addr_hit(addr_sync, `LINK1_OUTPUT_CLEAR_ADDR)) begin
          link1_clear <= write_mask(wdata_sync);
        end
      end
    end
  end

  // line-state read
  // Unmapped and write-only addresses read as zero
  always @* begin
    next_rdata = `READ_ZERO;
    if (addr_hit(addr_sync, `LINK0_LINE_STATE_ADDR)) begin
      next_rdata = state_word(link0_state);
    end else if (addr_hit(addr_sync, `LINK1_LINE_STATE_ADDR)) begin
      next_rdata = state_word(link1_state);
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_rdata <= `READ_ZERO;
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= oe_active;
      if (oe_active) begin
        o_rdata <= next_rdata;
      end
    end
  end

  // Open-collector pads: output value is a constant low
  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_link0_scl_out <= 1'b0;
      o_link0_sda_out <= 1'b0;
      o_link1_scl_out <= 1'b0;
      o_link1_sda_out <= 1'b0;
    end else begin
      o_link0_scl_out <= 1'b0;
      o_link0_sda_out <= 1'b0;
      o_link1_scl_out <= 1'b0;
      o_link1_sda_out <= 1'b0;
    end
  end

  bitbang_two_wire_port u_link0 (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_set(link0_set),
    .i_clear(link0_clear),
    .o_line_state(link0_state),
    .i_scl_in(i_link0_scl_in),
    .i_sda_in(i_link0_sda_in),
    .o_scl_oe(o_link0_scl_oe),
    .o_sda_oe(o_link0_sda_oe)
  );

  bitbang_two_wire_port u_link1 (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_set(link1_set),
    .i_clear(link1_clear),
    .o_line_state(link1_state),
    .i_scl_in(i_link1_scl_in),
    .i_sda_in(i_link1_sda_in),
    .o_scl_oe(o_link1_scl_oe),
    .o_sda_oe(o_link1_sda_oe)
  );

endmodule

// File: logic/two_wire_bitbang_map.vh
/*
 * Register map and field layout of the two software-driven two-wire ports.
 * Assumes byte addresses relative to the chip select base, 32-bit data.
 */
`ifndef TWO_WIRE_BITBANG_MAP_VH
`define TWO_WIRE_BITBANG_MAP_VH

// Link 0: switch configuration slave
`define LINK0_LINE_STATE_ADDR 20'h02000
`define LINK0_OUTPUT_SET_ADDR 20'h02000
`define LINK0_OUTPUT_CLEAR_ADDR 20'h02004

// Link 1: display data channel
`define LINK1_LINE_STATE_ADDR 20'h16000
`define LINK1_OUTPUT_SET_ADDR 20'h16000
`define LINK1_OUTPUT_CLEAR_ADDR 20'h16004

// Bit positions in every register of a link
`define CLOCK_BIT 0
`define DATA_BIT 1

// Output bits after reset: both lines released
`define OUTPUT_BITS_RESET 2'h3

// Idle levels of the synchronised lines and bus strobes
`define LINE_IDLE 2'h3
`define STROBES_IDLE 3'h7

// Unmapped reads and upper bits
`define READ_ZERO 32'h00000000

`endif

// File: logic/bitbang_two_wire_port.v
/*
 * One software-driven two-wire port: two stored output bits and the
 * synchronised line levels. Assumes set and clear arrive as one-cycle
 * strobes on i_sys_clk and that the lines are pulled up outside.
 */
`include "two_wire_bitbang_map.vh"

module bitbang_two_wire_port (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_reset,
  // Register side
  input wire [1:0] i_set,
  input wire [1:0] i_clear,
  output reg [1:0] o_line_state,
  // Lines
  input wire i_scl_in,
  input wire i_sda_in,
  output reg o_scl_oe,
  output reg o_sda_oe
);

  reg [1:0] output_bits;
  reg [1:0] next_output_bits;
  reg [1:0] line_meta;

  // Set wins if one write names a bit in both masks
  always @* begin
    next_output_bits = (output_bits & ~i_clear) | i_set;
  end

  always @(posedge i_sys_clk) begin
    if (i_reset) begin
      output_bits <= `OUTPUT_BITS_RESET;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      line_meta <= `LINE_IDLE;
      o_line_state <= `LINE_IDLE;
    end else begin
      output_bits <= next_output_bits;
      // open collector drive
      // Only a low is ever driven; a one releases the line
      o_scl_oe <= ~next_output_bits[`CLOCK_BIT];
      o_sda_oe <= ~next_output_bits[`DATA_BIT];
      line_meta <= {i_sda_in, i_scl_in};
      o_line_state <= line_meta;
    end
  end

endmodule

// File: sim/two_wire_bitbang_chk.sv
/* Port assertions for two_wire_bitbang_top.
   Assumes the bench holds address and data while a strobe is low. */
module two_wire_bitbang_chk (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_cs_n,
  input wire i_we_n,
  input wire i_oe_n,
  input wire [19:0] i_addr,
  input wire [31:0] i_wdata,
  input wire [31:0] o_rdata,
  input wire o_data_oe,
  input wire i_link0_scl_in,
  input wire i_link0_sda_in,
  input wire o_link0_sda_out,
  input wire o_link0_scl_oe,
  input wire o_link0_sda_oe,
  input wire o_link1_scl_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Write strobe one edge back, to spot its falling edge
  logic we_n_last = 1'b1;
  always @(posedge i_sys_clk) we_n_last <= i_we_n;
  wire wr = !i_cs_n && !i_we_n && we_n_last;
  wire rd = !i_cs_n && !i_oe_n && i_we_n;
  wire [1:0] pins = {i_link0_sda_in, i_link0_scl_in};
  chk_reset_release: assert property ($fell(i_reset) |->
    !o_link0_scl_oe && !o_link0_sda_oe) else $error("lines held");
  chk_never_high: assert property (o_link0_sda_out == 1'b0)
    else $error("data line driven high");
  chk_set_data: assert property (wr && i_addr == 20'h02000
    && i_wdata[1] |-> ##[2:6] !o_link0_sda_oe) else $error("set lost");
  chk_clear_data: assert property (wr && i_addr == 20'h02004
    && i_wdata[1] |-> ##[2:6] o_link0_sda_oe) else $error("clear lost");
  chk_link1_set: assert property (wr && i_addr == 20'h16000
    && i_wdata[0] |-> ##[2:6] !o_link1_scl_oe) else $error("link1 set");
  chk_read_drive: assert property ($fell(i_oe_n) && rd
    |-> ##[2:4] o_data_oe) else $error("no read drive");
  chk_upper_zero: assert property (o_data_oe |->
    o_rdata[31:2] == 30'h0) else $error("upper bits set");
  chk_pin_levels: assert property ((rd && i_addr == 20'h02000
    && $stable(pins)) [*6] |-> o_rdata[1:0] == pins)
    else $error("read differs from pins");
  cover property (rd && o_data_oe);
  cover property ($rose(o_link0_sda_oe));
  cover property ($rose(o_link1_scl_oe));
endmodule

// File: sim/two_wire_slave_model.sv
/* Pull-ups and slave pull-downs of both links.
   Assumes a high enable means the port pulls its line low. */
module two_wire_slave_model (
  input wire [3:0] i_oe,
  input wire [3:0] i_hold,
  output wire [3:0] o_line
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_line = ~(i_oe | i_hold);
endmodule

// File: sim/two_wire_bitbang_port_bench.sv
/* Register-level bench of two_wire_bitbang_top.
   Assumes the slave model pulls lines up unless someone holds them. */
module two_wire_bitbang_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, cs_n = 1, we_n = 1, oe_n = 1;
  logic [19:0] addr = 20'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] hold = 4'h0;
  wire [31:0] rdata;
  wire [3:0] oe, line, pout;
  wire data_oe;
  int error_cnt = 0, n_compared = 0;
  initial forever #5 clk = ~clk;
  two_wire_bitbang_top dut_u (.i_sys_clk(clk), .i_reset(rst),
    .i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(addr),
    .i_wdata(wdata), .o_rdata(rdata), .o_data_oe(data_oe),
    .i_link0_scl_in(line[0]), .o_link0_scl_out(pout[0]),
    .o_link0_scl_oe(oe[0]), .i_link0_sda_in(line[1]),
    .o_link0_sda_out(pout[1]), .o_link0_sda_oe(oe[1]),
    .i_link1_scl_in(line[2]), .o_link1_scl_out(pout[2]),
    .o_link1_scl_oe(oe[2]), .i_link1_sda_in(line[3]),
    .o_link1_sda_out(pout[3]), .o_link1_sda_oe(oe[3]));
  two_wire_slave_model far_u (.i_oe(oe), .i_hold(hold), .o_line(line));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    cs_n = 0;
    we_n = 0;
    repeat (6) @(negedge clk);
    cs_n = 1;
    we_n = 1;
    repeat (4) @(negedge clk);
  endtask
  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    @(negedge clk);
    addr = a;
    cs_n = 0;
    oe_n = 0;
    repeat (7) @(negedge clk);
    chk({31'h0, data_oe}, 32'h1);
    chk(rdata, e);
    cs_n = 1;
    oe_n = 1;
    repeat (4) @(negedge clk);
    chk({31'h0, data_oe}, 32'h0);
  endtask
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    wrap_up;
  end
  // line changes come from register writes, and in the pin-level test from the slave model's hold inputs
  initial begin
    repeat (12) @(negedge clk);
    rst = 0;
    rd(20'h02000, 32'h3);
    rd(20'h16000, 32'h3);
    chk({28'h0, oe}, 32'h0);
    $display("test reset done");
    wr(20'h02004, 32'h2);
    rd(20'h02000, 32'h1);
    wr(20'h02004, 32'hfffffffd);
    rd(20'h02000, 32'h0);
    chk({28'h0, oe}, 32'h3);
    chk({28'h0, pout}, 32'h0);
    wr(20'h02000, 32'h2);
    rd(20'h02000, 32'h2);
    wr(20'h02000, 32'h1);
    rd(20'h02000, 32'h3);
    wr(20'h16004, 32'h1);
    rd(20'h16000, 32'h2);
    wr(20'h16000, 32'h1);
    rd(20'h16000, 32'h3);
    wr(20'h16004, 32'h2);
    chk({28'h0, oe}, 32'h8);
    rd(20'h16000, 32'h1);
    wr(20'h16000, 32'h2);
    rd(20'h16000, 32'h3);
    $display("test set clear done");
    hold = 4'ha;
    rd(20'h02000, 32'h1);
    rd(20'h16000, 32'h1);
    hold = 4'h0;
    rd(20'h03000, 32'h0);
    $display("test pin levels done");
    wrap_up;
  end
endmodule
bind two_wire_bitbang_top two_wire_bitbang_chk chk_u (.i_sys_clk,
  .i_reset, .i_cs_n, .i_we_n, .i_oe_n, .i_addr, .i_wdata, .o_rdata,
  .o_data_oe, .i_link0_scl_in, .i_link0_sda_in, .o_link0_sda_out,
  .o_link0_scl_oe, .o_link0_sda_oe, .o_link1_scl_oe);
